// ==== verilog/ssi_core.v ====
// Function
// - Matching read address sets direction to read and buffers the address byte
// - After a read match, acknowledge on ninth bit then hold clock low
// - Writing transmit data to the buffer also loads the shift register
// - Clock stays held low until firmware sets the clock-release bit
// - Transmit shifts eight bits out MSB first on falling clock edges
// - Interrupt flag set on ninth falling edge per byte; software clears it
// - Master acknowledge latched on ninth rise; high ends transfer, slave idles
// - Low acknowledge keeps transmitting with clock held for the next byte
// - START/STOP bits cleared by reset or disable, else follow latest condition
// - Firmware master pins drive low only while direction bit selects output
// - Interrupt flag set on START and STOP in modes 1011, 1110 and 1111, and on each completed byte
// - Mode 1011 idles slave; modes 0110, 0111, 1110 and 1111 keep slave active beside firmware
// - Enabling interrupt while bus busy interrupts on next STOP
// - Slave keeps receiving after lost arbitration and acknowledges its address
// - On write addresses and data, full buffer or overflow sets overflow and withholds acknowledge
// - 10-bit address byte sets update flag and holds clock until rewritten
// - 10-bit read header acknowledged only after an earlier full match
// - Sample on rising edges, compare address on eighth falling edge
// - Buffer-full set on load, cleared by buffer read; overflow by software
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/100ps
`include "ssi_defs.vh"

module ssi_core (
  // Clock and reset
  input wire clk,
  input wire nrst,
  // Register port
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata_r,
  // Serial clock pin, open drain
  input wire scl_i,
  output reg scl_o_r,
  output reg scl_oe_r,
  // Serial data pin, open drain
  input wire sda_i,
  output reg sda_o_r,
  output reg sda_oe_r,
  // Peripheral interrupt request
  output reg irq_r
);

  // Slave state codes, one-hot
  localparam ST_IDLE = 5'h01;
  localparam ST_ADDR = 5'h02;
  localparam ST_ADLO = 5'h04;
  localparam ST_RCV = 5'h08;
  localparam ST_XMIT = 5'h10;

  // Software-visible registers
  reg [7:0] intctl_r;
  reg [7:0] irqf_r;
  reg [7:0] irqen_r;
  reg [7:0] buf_r;
  reg [7:0] dir_r;
  reg [7:0] addr_r;
  reg write_collision_flag_r;
  reg ov_r;
  reg en_r;
  reg ckp_r;
  reg [3:0] mode_r;
  reg [1:0] smpcke_r;
  reg da_r;
  reg stop_r;
  reg start_r;
  reg rw_r;
  reg ua_r;
  reg bf_r;

  // Slave engine state
  reg [4:0] st_r;
  reg [3:0] cnt_r;
  reg [7:0] sr_r;
  reg ack_drv_r;
  reg tx_en_r;
  reg stretch_r;
  reg nack_r;
  reg prior_r;
  reg ours_r;
  reg stop_pend_r;
  reg [7:0] rdata_nxt;

  // Synchronised lines and bus events
  wire [1:0] pins_s;
  wire scl_q;
  wire sda_q;
  wire e_rise;
  wire e_fall;
  wire e_start;
  wire e_stop;

  ssi_sync #(
    .W(2)
  ) u_sync (
    .clk(clk),
    .nrst(nrst),
    .d({scl_i, sda_i}),
    .q(pins_s)
  );

  ssi_cond u_cond (
    .clk(clk),
    .nrst(nrst),
    .scl_s(pins_s[1]),
    .sda_s(pins_s[0]),
    .scl_q(scl_q),
    .sda_q(sda_q),
    .scl_rise(e_rise),
    .scl_fall(e_fall),
    .bus_start(e_start),
    .bus_stop(e_stop)
  );

  // Register strobes
  wire wr_intctl = reg_wr & (reg_addr == `SSI_A_INTCTL);
  wire wr_irqf = reg_wr & (reg_addr == `SSI_A_IRQF);
  wire wr_irqen = reg_wr & (reg_addr == `SSI_A_IRQEN);
  wire wr_buf = reg_wr & (reg_addr == `SSI_A_BUF);
  wire wr_ctl = reg_wr & (reg_addr == `SSI_A_CTL);
  wire wr_dir = reg_wr & (reg_addr == `SSI_A_DIR);
  wire wr_addr = reg_wr & (reg_addr == `SSI_A_ADDR);
  wire wr_stat = reg_wr & (reg_addr == `SSI_A_STAT);
  wire rd_buf = reg_rd & (reg_addr == `SSI_A_BUF);
  wire ckp_set = wr_ctl & reg_wdata[`SSI_B_CKP];

  // Mode decode
  wire slv_on = en_r & ((mode_r == `SSI_M_SLV7) | (mode_r == `SSI_M_SLV10) |
    (mode_r == `SSI_M_SLV7SP) | (mode_r == `SSI_M_SLV10SP));
  wire ten_bit = (mode_r == `SSI_M_SLV10) | (mode_r == `SSI_M_SLV10SP);
  wire sp_int = (mode_r == `SSI_M_SLV7SP) | (mode_r == `SSI_M_SLV10SP) |
    (mode_r == `SSI_M_MSTFW);

  // Address compare terms
  wire hi_match = (sr_r[7:1] == addr_r[7:1]);
  wire ten_hdr = (sr_r[7:3] == `SSI_TEN_HDR);
  wire rx_busy = bf_r | ov_r;
  wire st_idle = st_r[0];
  wire st_xmit = st_r[4];
  wire in_byte = (cnt_r != 4'h0) & (cnt_r < `SSI_CNT_ACK);

  // Registers, slave engine and bus monitor
  always @(posedge clk) begin
    if (!nrst) begin
      intctl_r <= `SSI_RST_ZERO;
      irqf_r <= `SSI_RST_ZERO;
      irqen_r <= `SSI_RST_ZERO;
      buf_r <= `SSI_RST_ZERO;
      dir_r <= `SSI_RST_DIR;
      addr_r <= `SSI_RST_ZERO;
      write_collision_flag_r <= 1'b0;
      ov_r <= 1'b0;
      en_r <= 1'b0;
      ckp_r <= 1'b0;
      mode_r <= 4'h0;
      smpcke_r <= 2'h0;
      da_r <= 1'b0;
      stop_r <= 1'b0;
      start_r <= 1'b0;
      rw_r <= 1'b0;
      ua_r <= 1'b0;
      bf_r <= 1'b0;
      st_r <= ST_IDLE;
      cnt_r <= 4'h0;
      sr_r <= 8'h00;
      ack_drv_r <= 1'b0;
      tx_en_r <= 1'b0;
      stretch_r <= 1'b0;
      nack_r <= 1'b0;
      prior_r <= 1'b0;
      ours_r <= 1'b0;
      stop_pend_r <= 1'b0;
    end else begin
      // Software writes come first so hardware sets win below
      if (wr_intctl) intctl_r <= reg_wdata;
      if (wr_irqf) irqf_r <= reg_wdata;
      if (wr_irqen) irqen_r <= reg_wdata;
      if (wr_dir) dir_r <= reg_wdata;
      if (wr_addr) begin
        addr_r <= reg_wdata;
        ua_r <= 1'b0;
      end
      if (wr_stat) smpcke_r <= reg_wdata[7:6];
      if (wr_ctl) begin
        write_collision_flag_r <= reg_wdata[`SSI_B_WRITE_COLLISION_FLAG];
        ov_r <= reg_wdata[`SSI_B_OV];
        en_r <= reg_wdata[`SSI_B_EN];
        ckp_r <= reg_wdata[`SSI_B_CKP];
        mode_r <= reg_wdata[3:0];
      end
      if (rd_buf) bf_r <= 1'b0;
      // Enabling the interrupt on a busy bus arms a STOP interrupt
      if (wr_irqen & reg_wdata[`SSI_B_SPIF] & ~irqen_r[`SSI_B_SPIF] &
          start_r) begin
        stop_pend_r <= 1'b1;
      end
      // Buffer write loads the shift register unless a byte is going out
      if (wr_buf) begin
        if (tx_en_r & in_byte) begin
          write_collision_flag_r <= 1'b1;
        end else begin
          buf_r <= reg_wdata;
          sr_r <= reg_wdata;
        end
      end
      // Release of a stretched clock by firmware
      if (stretch_r & (ua_r ? wr_addr : ckp_set)) begin
        stretch_r <= 1'b0;
        if (st_xmit & ~ua_r) tx_en_r <= 1'b1;
      end

      if (!en_r) begin
        // Disabled module clears monitor bits and slave logic
        start_r <= 1'b0;
        stop_r <= 1'b0;
        st_r <= ST_IDLE;
        cnt_r <= 4'h0;
        ack_drv_r <= 1'b0;
        tx_en_r <= 1'b0;
        stretch_r <= 1'b0;
        stop_pend_r <= 1'b0;
      end else if (e_start) begin
        start_r <= 1'b1;
        stop_r <= 1'b0;
        if (sp_int) irqf_r[`SSI_B_SPIF] <= 1'b1;
        st_r <= slv_on ? ST_ADDR : ST_IDLE;
        cnt_r <= 4'h0;
        ack_drv_r <= 1'b0;
        tx_en_r <= 1'b0;
        stretch_r <= 1'b0;
        ours_r <= 1'b0;
      end else if (e_stop) begin
        stop_r <= 1'b1;
        start_r <= 1'b0;
        if (sp_int | stop_pend_r) begin
          irqf_r[`SSI_B_SPIF] <= 1'b1;
        end
        stop_pend_r <= 1'b0;
        st_r <= ST_IDLE;
        ack_drv_r <= 1'b0;
        tx_en_r <= 1'b0;
        stretch_r <= 1'b0;
      end else if (!slv_on) begin
        st_r <= ST_IDLE;
      end else if (e_rise & ~st_idle) begin
        // Sample incoming data, or latch the master acknowledge
        if (cnt_r < `SSI_CNT_ACK) begin
          if (!st_xmit) sr_r <= {sr_r[6:0], sda_q};
        end else if (st_xmit) begin
          nack_r <= sda_q;
        end
        if (cnt_r < `SSI_CNT_END) cnt_r <= cnt_r + 4'h1;
      end else if (e_fall & ~st_idle) begin
        // Transmit data moves while the clock is low
        if (st_xmit & tx_en_r & in_byte) begin
          sr_r <= {sr_r[6:0], 1'b0};
        end
        if (cnt_r == `SSI_CNT_ACK) begin
          // Eighth falling edge: decide on the byte
          tx_en_r <= 1'b0;
          case (st_r)
            ST_ADDR: begin
              if (!ten_bit) begin
                if (hi_match) begin
                  ours_r <= 1'b1;
                  da_r <= 1'b0;
                  rw_r <= sr_r[0];
                  if (sr_r[0]) begin
                    buf_r <= sr_r;
                    bf_r <= 1'b1;
                    ack_drv_r <= 1'b1;
                    nack_r <= 1'b0;
                    st_r <= ST_XMIT;
                  end else if (rx_busy) begin
                    ov_r <= 1'b1;
                    st_r <= ST_RCV;
                  end else begin
                    buf_r <= sr_r;
                    bf_r <= 1'b1;
                    ack_drv_r <= 1'b1;
                    st_r <= ST_RCV;
                  end
                end else begin
                  st_r <= ST_IDLE;
                end
              end else if (ten_hdr & hi_match & ~sr_r[0]) begin
                prior_r <= 1'b0;
                ours_r <= 1'b1;
                da_r <= 1'b0;
                rw_r <= 1'b0;
                if (rx_busy) begin
                  ov_r <= 1'b1;
                  st_r <= ST_IDLE;
                end else begin
                  buf_r <= sr_r;
                  bf_r <= 1'b1;
                  ua_r <= 1'b1;
                  ack_drv_r <= 1'b1;
                  st_r <= ST_ADLO;
                end
              end else if (ten_hdr & hi_match & sr_r[0] & prior_r) begin
                ours_r <= 1'b1;
                da_r <= 1'b0;
                rw_r <= 1'b1;
                buf_r <= sr_r;
                bf_r <= 1'b1;
                ack_drv_r <= 1'b1;
                nack_r <= 1'b0;
                st_r <= ST_XMIT;
              end else begin
                if (ten_hdr & hi_match) prior_r <= 1'b0;
                st_r <= ST_IDLE;
              end
            end
            ST_ADLO: begin
              ours_r <= 1'b1;
              if (rx_busy) begin
                ov_r <= 1'b1;
                st_r <= ST_IDLE;
              end else if (sr_r == addr_r) begin
                buf_r <= sr_r;
                bf_r <= 1'b1;
                ua_r <= 1'b1;
                prior_r <= 1'b1;
                ack_drv_r <= 1'b1;
                st_r <= ST_RCV;
              end else begin
                st_r <= ST_IDLE;
              end
            end
            ST_RCV: begin
              ours_r <= 1'b1;
              da_r <= 1'b1;
              if (rx_busy) begin
                ov_r <= 1'b1;
              end else begin
                buf_r <= sr_r;
                bf_r <= 1'b1;
                ack_drv_r <= 1'b1;
              end
            end
            ST_XMIT: begin
              ours_r <= 1'b1;
              da_r <= 1'b1;
            end
            default: begin
              st_r <= ST_IDLE;
            end
          endcase
        end else if (cnt_r == `SSI_CNT_END) begin
          // Ninth falling edge: end of byte
          if (ours_r) irqf_r[`SSI_B_SPIF] <= 1'b1;
          ours_r <= 1'b0;
          ack_drv_r <= 1'b0;
          cnt_r <= 4'h0;
          if (st_xmit) begin
            if (nack_r) begin
              st_r <= ST_IDLE;
            end else begin
              stretch_r <= 1'b1;
              ckp_r <= 1'b0;
            end
          end
          if (ua_r) stretch_r <= 1'b1;
        end
      end
    end
  end

  // Open-drain pin drivers; level is always low when enabled
  always @(posedge clk) begin
    if (!nrst) begin
      scl_o_r <= 1'b0;
      sda_o_r <= 1'b0;
      scl_oe_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end else begin
      scl_o_r <= 1'b0;
      sda_o_r <= 1'b0;
      scl_oe_r <= en_r & (~dir_r[`SSI_B_DIR_SCL] | stretch_r);
      sda_oe_r <= en_r & (~dir_r[`SSI_B_DIR_SDA] | ack_drv_r |
        (tx_en_r & ~sr_r[7]));
    end
  end

  // Read data mux
  always @* begin
    case (reg_addr)
      `SSI_A_INTCTL: rdata_nxt = intctl_r;
      `SSI_A_IRQF: rdata_nxt = irqf_r;
      `SSI_A_IRQEN: rdata_nxt = irqen_r;
      `SSI_A_BUF: rdata_nxt = buf_r;
      `SSI_A_CTL: rdata_nxt = {write_collision_flag_r, ov_r, en_r, ckp_r, mode_r};
      `SSI_A_DIR: rdata_nxt = dir_r;
      `SSI_A_ADDR: rdata_nxt = addr_r;
      `SSI_A_STAT: rdata_nxt = {smpcke_r, da_r, stop_r, start_r, rw_r, ua_r,
        bf_r};
      default: rdata_nxt = 8'h00;
    endcase
  end

  // Read data one cycle after the strobe, and the interrupt request
  always @(posedge clk) begin
    if (!nrst) begin
      reg_rdata_r <= 8'h00;
      irq_r <= 1'b0;
    end else begin
      reg_rdata_r <= reg_rd ? rdata_nxt : 8'h00;
      irq_r <= intctl_r[`SSI_B_GIE] & intctl_r[`SSI_B_PEIE] &
        irqf_r[`SSI_B_SPIF] & irqen_r[`SSI_B_SPIF];
    end
  end

endmodule

// ==== verilog/ssi_defs.vh ====
`ifndef SSI_DEFS_VH
`define SSI_DEFS_VH

// Register offsets on the register port
`define SSI_A_INTCTL 8'h0b
`define SSI_A_IRQF 8'h0c
`define SSI_A_BUF 8'h13
`define SSI_A_CTL 8'h14
`define SSI_A_DIR 8'h87
`define SSI_A_IRQEN 8'h8c
`define SSI_A_ADDR 8'h93
`define SSI_A_STAT 8'h94

// Reset values
`define SSI_RST_ZERO 8'h00
`define SSI_RST_DIR 8'h3f

// Control register fields
`define SSI_B_WRITE_COLLISION_FLAG 7
`define SSI_B_OV 6
`define SSI_B_EN 5
`define SSI_B_CKP 4

// Status register fields
`define SSI_B_DA 5
`define SSI_B_STOP 4
`define SSI_B_START 3
`define SSI_B_RW 2
`define SSI_B_UA 1
`define SSI_B_BF 0

// Interrupt flag, enable and core interrupt control fields
`define SSI_B_SPIF 3
`define SSI_B_GIE 7
`define SSI_B_PEIE 6

// Direction bits of the clock and data pins
`define SSI_B_DIR_SCL 3
`define SSI_B_DIR_SDA 4

// Port mode select codes
`define SSI_M_SLV7 4'h6
`define SSI_M_SLV10 4'h7
`define SSI_M_MSTFW 4'hb
`define SSI_M_SLV7SP 4'he
`define SSI_M_SLV10SP 4'hf

// Header of a 10-bit address high byte, bits 7 to 3
`define SSI_TEN_HDR 5'h1e

// Bit counts within one byte transfer
`define SSI_CNT_ACK 4'h8
`define SSI_CNT_END 4'h9

`endif

// ==== verilog/ssi_sync.v ====
`timescale 1ns/100ps
`include "ssi_defs.vh"

// Two-stage synchroniser for pin levels; idles high like the bus
module ssi_sync #(
  parameter W = 2
) (
  // Clock and reset
  input wire clk,
  input wire nrst,
  // Asynchronous levels in, synchronised levels out
  input wire [W-1:0] d,
  output reg [W-1:0] q
);

  reg [W-1:0] meta_r;

  // First stage feeds only the second stage
  always @(posedge clk) begin
    if (!nrst) begin
      meta_r <= {W{1'b1}};
      q <= {W{1'b1}};
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule

// ==== verilog/ssi_cond.v ====
`timescale 1ns/100ps
`include "ssi_defs.vh"

// Finds clock edges and bus START/STOP conditions on synchronised lines
module ssi_cond (
  // Clock and reset
  input wire clk,
  input wire nrst,
  // Synchronised bus lines
  input wire scl_s,
  input wire sda_s,
  // Aligned line levels and one-cycle event pulses
  output reg scl_q,
  output reg sda_q,
  output wire scl_rise,
  output wire scl_fall,
  output wire bus_start,
  output wire bus_stop
);

  reg scl_p;
  reg sda_p;

  // Two history stages give current and previous levels
  always @(posedge clk) begin
    if (!nrst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      scl_p <= 1'b1;
      sda_p <= 1'b1;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
      scl_p <= scl_q;
      sda_p <= sda_q;
    end
  end

  // Edges of the clock line
  assign scl_rise = scl_q & ~scl_p;
  assign scl_fall = ~scl_q & scl_p;
  // Data moving while clock stays high
  assign bus_start = scl_q & scl_p & sda_p & ~sda_q;
  assign bus_stop = scl_q & scl_p & ~sda_p & sda_q;

endmodule

// ==== test/ssi_checker.sv ====
`timescale 1ns/100ps
`include "ssi_defs.vh"

// Watches register strobes and pin drives of the serial core
module ssi_checker (
  // Clock and reset
  input logic clk,
  input logic nrst,
  // Register port
  input logic [7:0] reg_addr,
  input logic [7:0] reg_wdata,
  input logic reg_wr,
  input logic reg_rd,
  input logic [7:0] reg_rdata_r,
  // Open-drain pins and interrupt
  input logic scl_i,
  input logic scl_o_r,
  input logic scl_oe_r,
  input logic sda_i,
  input logic sda_o_r,
  input logic sda_oe_r,
  input logic irq_r
);
  reg [7:0] dir_r;
  reg [7:0] ctl_r;
  reg ien_r;
  reg [1:0] quiet_r;
  wire fw = ctl_r[`SSI_B_EN] && ctl_r[3:0] == `SSI_M_MSTFW;

  // Shadows of software-only fields and a settle counter
  always @(posedge clk) begin
    if (!nrst) begin
      dir_r <= `SSI_RST_DIR;
      ctl_r <= `SSI_RST_ZERO;
      ien_r <= 1'b0;
      quiet_r <= 2'h0;
    end else if (reg_wr && reg_addr == `SSI_A_DIR) begin
      dir_r <= reg_wdata;
      quiet_r <= 2'h0;
    end else if (reg_wr && reg_addr == `SSI_A_CTL) begin
      ctl_r <= reg_wdata;
      quiet_r <= 2'h0;
    end else if (reg_wr && reg_addr == `SSI_A_IRQEN) begin
      ien_r <= reg_wdata[`SSI_B_SPIF];
    end else if (quiet_r != 2'h3) begin
      quiet_r <= quiet_r + 2'h1;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  // Release of a transmit stretch by the clock-release bit
  sequence s_release_wr;
    reg_wr && reg_addr == `SSI_A_CTL && reg_wdata[`SSI_B_CKP];
  endsequence
  sequence s_scl_freed;
    ##[1:3] !scl_oe_r;
  endsequence

  a_pins_low: assert property (!scl_o_r && !sda_o_r)
    else $error("pin drive level not low");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata_r == 8'h00)
    else $error("read data outside its cycle");
  a_stretch_hold: assert property (
    scl_oe_r && !reg_wr && !$past(reg_wr) && !$past(reg_wr, 2) |=> scl_oe_r)
    else $error("clock released without a write");
  a_ckp_free: assert property (
    s_release_wr ##0 (scl_oe_r && !ctl_r[0] && dir_r[`SSI_B_DIR_SCL])
    |-> s_scl_freed)
    else $error("clock not released after release bit");
  a_stretch_start: assert property (
    $rose(scl_oe_r) && dir_r[`SSI_B_DIR_SCL] |-> !$past(scl_i))
    else $error("clock pulled while line high");
  a_sda_moves: assert property (
    $changed(sda_oe_r) && !fw && dir_r[`SSI_B_DIR_SDA] |-> !$past(scl_i))
    else $error("data drive changed while clock high");
  a_fw_pins: assert property (
    fw && quiet_r == 2'h3 |-> scl_oe_r == !dir_r[`SSI_B_DIR_SCL]
      && sda_oe_r == !dir_r[`SSI_B_DIR_SDA])
    else $error("firmware pin drive does not follow direction");
  a_irq_sw_clear: assert property (
    $fell(irq_r) |-> $past(reg_wr) || $past(reg_wr, 2) || $past(reg_wr, 3))
    else $error("interrupt dropped without a write");
  a_irq_masked: assert property (!$past(ien_r) |-> !irq_r)
    else $error("interrupt while disabled");
endmodule

// ==== test/ssi_mst.sv ====
`timescale 1ns/100ps

// Bus master on the far side; only pulls the open-drain lines low
module ssi_mst (
  // Resolved line levels
  input wire scl,
  input wire sda,
  // Pulls, high holds the line low
  output reg scl_low,
  output reg sda_low
);
  reg stuck;
  integer n;

  // Lines released; the clock stands still between frames
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
    stuck = 1'b0;
  end

  // One pulse: set data while low, sample it while high
  task bit_cyc(input logic b, output logic r);
    begin
      #20 sda_low = !b;
      #20 scl_low = 1'b0;
      n = 0;
      while (!scl && n < 2000) begin
        #8 n = n + 1;
      end
      stuck = stuck | !scl;
      #20 r = sda;
      #20 scl_low = 1'b1;
    end
  endtask
  // Another master holding data low, for arbitration loss
  task hold_sda(input logic b);
    sda_low = b;
  endtask
  // Data falls with clock high; only issued on an idle bus
  task start_c;
    begin
      sda_low = 1'b1;
      #40 scl_low = 1'b1;
    end
  endtask
  // Data rises with clock high
  task stop_c;
    begin
      sda_low = 1'b1;
      #40 scl_low = 1'b0;
      #40 sda_low = 1'b0;
      #80;
    end
  endtask
  // Byte out MSB first; a is the ninth bit seen
  task send(input logic [7:0] d, output logic a);
    integer k;
    begin
      for (k = 7; k >= 0; k = k - 1) begin
        bit_cyc(d[k], a);
      end
      bit_cyc(1'b1, a);
    end
  endtask
  // Byte in MSB first, then our acknowledge level ab
  task recv(input logic ab, output logic [7:0] d);
    integer k;
    logic x;
    begin
      for (k = 7; k >= 0; k = k - 1) begin
        bit_cyc(1'b1, d[k]);
      end
      bit_cyc(ab, x);
    end
  endtask
endmodule

// ==== test/tb_top.sv ====
`timescale 1ns/100ps
`include "ssi_defs.vh"

module tb_top;
  // Design ports and the resolved open-drain lines
  logic clk, nrst, reg_wr, reg_rd, ak;
  logic [7:0] reg_addr, reg_wdata, v;
  wire [7:0] reg_rdata_r;
  wire scl_o_r, scl_oe_r, sda_o_r, sda_oe_r, irq_r, m_scl_low, m_sda_low;
  wire scl_i = !(scl_oe_r || m_scl_low);
  wire sda_i = !(sda_oe_r || m_sda_low);
  integer errors, samples_checked, i;
  logic [7:0] ra [0:8] = '{`SSI_A_INTCTL, `SSI_A_IRQF, `SSI_A_BUF,
    `SSI_A_CTL, `SSI_A_DIR, `SSI_A_IRQEN, `SSI_A_ADDR, `SSI_A_STAT, 8'h55};
  logic [7:0] tx [0:1] = '{8'h96, 8'h5a};

  ssi_core dut (.clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata_r, .scl_i, .scl_o_r, .scl_oe_r, .sda_i, .sda_o_r,
    .sda_oe_r, .irq_r);
  ssi_mst mst (.scl(scl_i), .sda(sda_i), .scl_low(m_scl_low),
    .sda_low(m_sda_low));

  // Register port cycles; both end just after an edge
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task rd(input logic [7:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata_r;
  endtask
  // Byte compare, plus read-and-compare and pin-drive wrappers
  task chk(input string n, input logic [7:0] e, input logic [7:0] s);
    samples_checked = samples_checked + 1;
    if (s !== e) begin
      errors = errors + 1;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task rchk(input string n, input logic [7:0] a, m, e);
    rd(a);
    chk(n, e, v & m);
  endtask
  task pins(input logic [7:0] e);
    repeat (8) @(posedge clk);
    #1 chk("pin drive", e, {6'h0, scl_oe_r, sda_oe_r});
  endtask
  task stop_test;
    $display("Comparisons %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Watchdog against a hung bus
  initial begin
    #200000;
    errors = errors + 1;
    stop_test;
  end

  // Main sequence
  initial begin
    {nrst, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    errors = 0;
    samples_checked = 0;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    for (i = 0; i < 9; i = i + 1) begin
      rchk("reset value", ra[i], 8'hff,
        ra[i] == `SSI_A_DIR ? `SSI_RST_DIR : `SSI_RST_ZERO);
    end
    wr(8'h55, 8'hff);
    wr(`SSI_A_STAT, 8'h3f);
    rchk("status read only", `SSI_A_STAT, 8'h3f, 8'h00);
    rchk("unmapped", 8'h55, 8'hff, 8'h00);
    wr(`SSI_A_ADDR, 8'ha4);
    rchk("address", `SSI_A_ADDR, 8'hff, 8'ha4);
    wr(`SSI_A_INTCTL, 8'hc0);
    wr(`SSI_A_IRQEN, 8'h08);
    wr(`SSI_A_CTL, 8'h2e);
    // Read transfer: two bytes out, the second refused by the master
    mst.start_c;
    pins(8'h00);
    chk("irq", 8'h01, {7'h0, irq_r});
    rchk("status", `SSI_A_STAT, 8'h18, 8'h08);
    wr(`SSI_A_IRQF, 8'h00);
    mst.send(8'ha5, ak);
    chk("address ack", 8'h00, {7'h0, ak});
    pins(8'h02);
    rchk("status", `SSI_A_STAT, 8'h1f, 8'h0d);
    rchk("irq flags", `SSI_A_IRQF, 8'h08, 8'h08);
    rchk("buffer", `SSI_A_BUF, 8'hff, 8'ha5);
    rchk("buffer full", `SSI_A_STAT, 8'h01, 8'h00);
    wr(`SSI_A_IRQF, 8'h00);
    for (i = 0; i < 2; i = i + 1) begin
      wr(`SSI_A_BUF, tx[i]);
      wr(`SSI_A_CTL, 8'h3e);
      pins({7'h0, !tx[i][7]});
      mst.recv(i[0], v);
      chk("sent byte", tx[i], v);
      pins({6'h0, !i[0], 1'b0});
      rchk("irq flags", `SSI_A_IRQF, 8'h08, 8'h08);
      wr(`SSI_A_IRQF, 8'h00);
    end
    mst.stop_c;
    rchk("status", `SSI_A_STAT, 8'h18, 8'h10);
    rchk("irq flags", `SSI_A_IRQF, 8'h08, 8'h08);
    // Address differing only in its lowest compared bit
    mst.start_c;
    mst.send(8'ha6, ak);
    chk("foreign ack", 8'h01, {7'h0, ak});
    mst.stop_c;
    // Write transfer: third byte meets a full buffer
    rd(`SSI_A_BUF);
    wr(`SSI_A_CTL, 8'h2e);
    mst.start_c;
    mst.send(8'ha4, ak);
    chk("write address ack", 8'h00, {7'h0, ak});
    rchk("buffer", `SSI_A_BUF, 8'hff, 8'ha4);
    mst.send(8'h3c, ak);
    chk("data ack", 8'h00, {7'h0, ak});
    mst.send(8'h77, ak);
    chk("full ack", 8'h01, {7'h0, ak});
    rchk("overflow", `SSI_A_CTL, 8'h40, 8'h40);
    rchk("buffer", `SSI_A_BUF, 8'hff, 8'h3c);
    mst.stop_c;
    // Interrupt enabled on a busy bus fires at the next STOP
    wr(`SSI_A_IRQF, 8'h00);
    wr(`SSI_A_IRQEN, 8'h00);
    wr(`SSI_A_CTL, 8'h26);
    mst.start_c;
    wr(`SSI_A_IRQEN, 8'h08);
    rchk("irq flags", `SSI_A_IRQF, 8'h08, 8'h00);
    mst.stop_c;
    rchk("irq flags", `SSI_A_IRQF, 8'h08, 8'h08);
    // 10-bit write address: each byte stalls until the address is rewritten
    wr(`SSI_A_ADDR, 8'hf0);
    wr(`SSI_A_CTL, 8'h27);
    mst.start_c;
    mst.send(8'hf0, ak);
    chk("high address ack", 8'h00, {7'h0, ak});
    pins(8'h02);
    rchk("update flag", `SSI_A_STAT, 8'h03, 8'h03);
    rchk("buffer", `SSI_A_BUF, 8'hff, 8'hf0);
    wr(`SSI_A_ADDR, 8'h3c);
    pins(8'h00);
    rchk("update flag", `SSI_A_STAT, 8'h03, 8'h00);
    mst.send(8'h3c, ak);
    chk("low address ack", 8'h00, {7'h0, ak});
    pins(8'h02);
    wr(`SSI_A_ADDR, 8'hf0);
    mst.stop_c;
    // Firmware master: start and stop made through direction bits
    wr(`SSI_A_CTL, 8'h2b);
    wr(`SSI_A_DIR, 8'h2f);
    pins(8'h01);
    rchk("status", `SSI_A_STAT, 8'h18, 8'h08);
    wr(`SSI_A_DIR, 8'h27);
    pins(8'h03);
    // Lost arbitration: a one sent while another master holds data low
    wr(`SSI_A_DIR, 8'h37);
    mst.hold_sda(1'b1);
    pins(8'h02);
    if (!sda_i) wr(`SSI_A_DIR, 8'h3f);
    pins(8'h00);
    mst.hold_sda(1'b0);
    wr(`SSI_A_DIR, 8'h2f);
    wr(`SSI_A_DIR, 8'h3f);
    pins(8'h00);
    rchk("status", `SSI_A_STAT, 8'h18, 8'h10);
    wr(`SSI_A_CTL, 8'h0b);
    rchk("status", `SSI_A_STAT, 8'h18, 8'h00);
    chk("stretch wait", 8'h00, {7'h0, mst.stuck});
    stop_test;
  end
endmodule

bind ssi_core ssi_checker u_chk (.clk, .nrst, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata_r, .scl_i, .scl_o_r, .scl_oe_r, .sda_i,
  .sda_o_r, .sda_oe_r, .irq_r);
